//--- verilog/srack_pkg.sv
// Purpose: Shared constants and types of the service request and acknowledge block.
// Assumes: Seven-bit register address and eight-bit data, as on the device pins.
// Notes:   Register addresses sit in the global half of the map (top address bit set).
`default_nettype none
package srack_pkg;

  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned DATA_W   = 8;

  localparam logic [6:0] ADDR_VECTOR    = 7'h40;
  localparam logic [6:0] ADDR_STATUS    = 7'h41;
  localparam logic [6:0] ADDR_RX_ACK    = 7'h42;
  localparam logic [6:0] ADDR_TX_ACK    = 7'h43;
  localparam logic [6:0] ADDR_MODEM_ACK = 7'h44;
  localparam logic [6:0] ADDR_CTRL      = 7'h45;

  localparam logic [7:0] VECTOR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam int unsigned CTRL_CHAIN_BIT = 0;

  localparam int unsigned VEC_TYPE_LSB = 0;
  localparam int unsigned VEC_TYPE_MSB = 2;
  localparam int unsigned VEC_ID_LSB   = 3;
  localparam int unsigned VEC_ID_MSB   = 7;

  localparam logic [2:0] TYPE_NONE  = 3'h0;
  localparam logic [2:0] TYPE_RX    = 3'h1;
  localparam logic [2:0] TYPE_TX    = 3'h2;
  localparam logic [2:0] TYPE_MODEM = 3'h3;

  localparam int unsigned STATUS_OWN_LSB  = 0;
  localparam int unsigned STATUS_LINE_LSB = 3;

  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // One acknowledge handed to the channel engines.
  typedef struct packed {
    logic       valid;
    logic [2:0] kind;
    logic [2:0] chan;
  } srack_ack_s;

  // Host bus pins as seen by the block.
  typedef struct packed {
    logic       chip_select_n;
    logic       data_strobe_n;
    logic       read_n_write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } srack_bus_s;

endpackage
`default_nettype wire

//--- verilog/srack_arbiter.sv
// Purpose: Round-robin pick of one requesting channel for one request type.
// Assumes: NUM is a power of two so pointer arithmetic wraps naturally.
// Notes:   The pointer moves past the granted channel each time it is served.
`timescale 1ns/10ps
`default_nettype none
module srack_arbiter #(
  parameter int unsigned NUM = 8,
  parameter int unsigned IW  = $clog2(NUM)
) (
  input  wire logic           mclk_i,
  input  wire logic           sys_rst_i,
  input  wire logic [NUM-1:0] req_i,
  input  wire logic           served_i,
  output logic                any_o,
  output logic [IW-1:0]       grant_o
);

  logic [IW-1:0] ptr;

  always_comb begin
    logic [IW-1:0] j;
    j       = '0;
    grant_o = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      j = ptr + IW'(i);
      if (req_i[j]) begin
        grant_o = j;
      end
    end
  end

  assign any_o = |req_i;

  // The device, not the host, rotates service among the channels.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr <= '0;
    end else if (served_i && any_o) begin
      ptr <= grant_o + IW'(1);
    end
  end

endmodule
`default_nettype wire

//--- verilog/srack_top.sv
// Purpose: Service request pins, acknowledge cycles, acknowledge registers and chaining.
// Assumes: Bus pins are synchronous to mclk_i; one action per strobe assertion.
// Notes:   Request pins are open drain; the wired level comes back on the _i inputs.
`timescale 1ns/10ps
`default_nettype none
module srack_top #(
  parameter int unsigned NUM_CHAN = srack_pkg::NUM_CHAN
) (
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  input  wire srack_pkg::srack_bus_s bus_i,
  input  wire logic                ack_chain_in_n_i,
  output logic                     ack_chain_out_n_o,
  output logic [7:0]               data_o,
  output logic                     data_oe_o,
  input  wire logic [NUM_CHAN-1:0] rx_chan_req_i,
  input  wire logic [NUM_CHAN-1:0] tx_chan_req_i,
  input  wire logic [NUM_CHAN-1:0] modem_chan_req_i,
  input  wire logic                rx_service_request_n_i,
  input  wire logic                tx_service_request_n_i,
  input  wire logic                modem_service_request_n_i,
  output logic                     rx_service_request_n_o,
  output logic                     tx_service_request_n_o,
  output logic                     modem_service_request_n_o,
  output logic                     rx_service_request_n_oe_o,
  output logic                     tx_service_request_n_oe_o,
  output logic                     modem_service_request_n_oe_o,
  output srack_pkg::srack_ack_s    ack_evt_o,
  output logic                     chain_enable_o
);

  localparam int unsigned IW = $clog2(NUM_CHAN);

  logic [7:0]    global_interrupt_vector;
  logic [7:0]    ctrl;
  logic          strobe_q;
  logic [2:0]    own_pend;
  logic [2:0]    served;
  logic [2:0]    any_type;
  logic [IW-1:0] grant [3];

  logic          strobe;
  logic          start;
  logic          hw_cyc;
  logic          sw_rd;
  logic          sw_wr;
  logic          ack_rd;
  logic [2:0]    ack_sel;
  logic [2:0]    kind;
  logic [IW-1:0] chan;
  logic [7:0]    vector;
  logic [7:0]    next_data;

  assign strobe = !bus_i.data_strobe_n;
  assign start  = strobe && !strobe_q;
  assign hw_cyc = start && bus_i.chip_select_n && !ack_chain_in_n_i;
  assign sw_rd  = start && !bus_i.chip_select_n && bus_i.read_n_write;
  assign sw_wr  = start && !bus_i.chip_select_n && !bus_i.read_n_write;
  assign ack_sel = {sw_rd && bus_i.addr == srack_pkg::ADDR_MODEM_ACK,
                    sw_rd && bus_i.addr == srack_pkg::ADDR_TX_ACK,
                    sw_rd && bus_i.addr == srack_pkg::ADDR_RX_ACK};
  assign ack_rd = |ack_sel;
  assign any_type = own_pend;

  for (genvar t = 0; t < 3; t++) begin : g_arb
    srack_arbiter #(.NUM(NUM_CHAN), .IW(IW)) u_arb (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .req_i     (t == 0 ? rx_chan_req_i : (t == 1 ? tx_chan_req_i : modem_chan_req_i)),
      .served_i  (served[t]),
      .any_o     (own_pend[t]),
      .grant_o   (grant[t])
    );
  end

  // Chooses the kind being acknowledged; a hardware cycle serves receive first.
  always_comb begin
    kind   = srack_pkg::TYPE_NONE;
    chan   = '0;
    served = 3'h0;
    if (ack_rd) begin
      if (ack_sel[0] && own_pend[0]) begin
        served[0] = 1'b1;
      end else if (ack_sel[1] && own_pend[1]) begin
        served[1] = 1'b1;
      end else if (ack_sel[2] && own_pend[2]) begin
        served[2] = 1'b1;
      end
    end else if (hw_cyc) begin
      if (own_pend[0]) begin
        served[0] = 1'b1;
      end else if (own_pend[1]) begin
        served[1] = 1'b1;
      end else if (own_pend[2]) begin
        served[2] = 1'b1;
      end
    end
    if (served[0]) begin
      kind = srack_pkg::TYPE_RX;
      chan = grant[0];
    end else if (served[1]) begin
      kind = srack_pkg::TYPE_TX;
      chan = grant[1];
    end else if (served[2]) begin
      kind = srack_pkg::TYPE_MODEM;
      chan = grant[2];
    end
  end

  // Identity in the upper bits, request kind in the low bits.
  assign vector = {global_interrupt_vector[srack_pkg::VEC_ID_MSB:srack_pkg::VEC_ID_LSB],
                   kind};

  always_comb begin
    next_data = srack_pkg::READ_UNMAPPED;
    if (hw_cyc || ack_rd) begin
      next_data = vector;
    end else if (bus_i.addr == srack_pkg::ADDR_VECTOR) begin
      next_data = global_interrupt_vector;
    end else if (bus_i.addr == srack_pkg::ADDR_STATUS) begin
      next_data = {2'h0,
                   !modem_service_request_n_i,
                   !tx_service_request_n_i,
                   !rx_service_request_n_i,
                   own_pend};
    end else if (bus_i.addr == srack_pkg::ADDR_CTRL) begin
      next_data = ctrl;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      global_interrupt_vector <= srack_pkg::VECTOR_RST;
      ctrl                    <= srack_pkg::CTRL_RST;
    end else if (sw_wr && bus_i.addr == srack_pkg::ADDR_VECTOR) begin
      global_interrupt_vector <= bus_i.wdata;
    end else if (sw_wr && bus_i.addr == srack_pkg::ADDR_CTRL) begin
      ctrl <= bus_i.wdata;
    end
  end

  assign chain_enable_o = ctrl[srack_pkg::CTRL_CHAIN_BIT];

  // Read data and its enable stand until the strobe is released.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else if (!strobe) begin
      data_oe_o <= 1'b0;
    end else if (hw_cyc && |own_pend) begin
      data_o    <= next_data;
      data_oe_o <= 1'b1;
    end else if (sw_rd && !(ack_rd && kind == srack_pkg::TYPE_NONE && chain_enable_o)) begin
      data_o    <= next_data;
      data_oe_o <= 1'b1;
    end
  end

  // The chain output follows the strobe once this device declines the cycle.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_chain_out_n_o <= 1'b1;
    end else if (!strobe) begin
      ack_chain_out_n_o <= 1'b1;
    end else if (hw_cyc && !(|own_pend)) begin
      ack_chain_out_n_o <= 1'b0;
    end else if (ack_rd && kind == srack_pkg::TYPE_NONE && chain_enable_o) begin
      ack_chain_out_n_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_evt_o <= '0;
    end else begin
      ack_evt_o.valid <= |served;
      ack_evt_o.kind  <= kind;
      ack_evt_o.chan  <= 3'(chan);
    end
  end

  // Open drain: the pin is only ever pulled low, the enable carries the request.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_service_request_n_o       <= 1'b0;
      tx_service_request_n_o       <= 1'b0;
      modem_service_request_n_o    <= 1'b0;
      rx_service_request_n_oe_o    <= 1'b0;
      tx_service_request_n_oe_o    <= 1'b0;
      modem_service_request_n_oe_o <= 1'b0;
    end else begin
      rx_service_request_n_oe_o    <= any_type[0];
      tx_service_request_n_oe_o    <= any_type[1];
      modem_service_request_n_oe_o <= any_type[2];
    end
  end

  AST_OD_LOW: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !rx_service_request_n_o && !tx_service_request_n_o && !modem_service_request_n_o)
    else $error("request pin drives high");
  AST_OD_FOLLOW: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    own_pend[0] |=> rx_service_request_n_oe_o)
    else $error("receive request not driven");
  AST_SW_ACK: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ack_sel[0] && own_pend[0]) |=> ack_evt_o.valid && data_oe_o
      && ack_evt_o.kind == srack_pkg::TYPE_RX)
    else $error("receive acknowledge read not served");
  AST_TYPE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ack_evt_o.valid |-> data_o[2:0] == ack_evt_o.kind)
    else $error("vector type differs from acknowledged kind");
  AST_ID: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ack_evt_o.valid |-> data_o[7:3] == global_interrupt_vector[7:3])
    else $error("vector identity wrong");
  AST_CHAIN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ack_rd && !(|(ack_sel & own_pend)) && chain_enable_o) |=> !ack_chain_out_n_o && !data_oe_o)
    else $error("empty read did not chain");
  AST_NOCHAIN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ack_rd && !(|(ack_sel & own_pend)) && !chain_enable_o) |=>
      data_o[2:0] == srack_pkg::TYPE_NONE && ack_chain_out_n_o && data_oe_o)
    else $error("empty read without chain not zero");
  AST_HW_DRIVE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (hw_cyc && |own_pend) |=> data_oe_o && ack_evt_o.valid && ack_chain_out_n_o)
    else $error("hardware acknowledge not answered");
  AST_HW_PASS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (hw_cyc && !(|own_pend)) |=> !ack_chain_out_n_o && !data_oe_o)
    else $error("hardware acknowledge not passed on");
  AST_STATUS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (sw_rd && bus_i.addr == srack_pkg::ADDR_STATUS) |=> data_o[2:0] == $past(own_pend))
    else $error("status pending bits wrong");
  AST_RELEASE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !strobe |=> ack_chain_out_n_o && !data_oe_o)
    else $error("chain held after strobe release");

  COV_SW_ACK:  cover property (@(posedge mclk_i) disable iff (sys_rst_i) ack_rd && |served);
  COV_HW_ACK:  cover property (@(posedge mclk_i) disable iff (sys_rst_i) hw_cyc && |own_pend);
  COV_PASS:    cover property (@(posedge mclk_i) disable iff (sys_rst_i) hw_cyc && !(|own_pend));
  COV_STATUS:  cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    sw_rd && bus_i.addr == srack_pkg::ADDR_STATUS);

endmodule
`default_nettype wire

//--- verification/srack_host_model.sv
// Purpose: Host side of the bus plus the wired request lines of a chain.
// Assumes: One access at a time; answers arrive within three cycles.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module srack_host_model (
  input  wire logic                  mclk_i,
  input  wire logic [2:0]            own_oe_i,
  input  wire logic [2:0]            other_req_i,
  input  wire logic [7:0]            data_i,
  input  wire logic                  data_oe_i,
  input  wire logic                  ack_out_n_i,
  input  wire srack_pkg::srack_ack_s ack_evt_i,
  output srack_pkg::srack_bus_s      bus_o,
  output logic                       ack_in_n_o,
  output logic [2:0]                 line_n_o
);
  // A line is low while any device on the chain pulls it.
  assign line_n_o = ~(own_oe_i | other_req_i);

  initial begin
    bus_o = '{1'b1, 1'b1, 1'b1, 7'h00, 8'h00};
    ack_in_n_o = 1'b1;
  end

  task automatic cycle(input logic cs_n, input logic ack_n, input logic rnw,
                       input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output logic got, output logic chn,
                       output srack_pkg::srack_ack_s ev);
    rd = 8'h00;
    got = 1'b0;
    chn = 1'b0;
    ev = '0;
    @(posedge mclk_i);
    bus_o <= '{cs_n, 1'b0, rnw, a, wd};
    ack_in_n_o <= ack_n;
    repeat (3) begin
      @(posedge mclk_i);
      #1;
      if (data_oe_i === 1'b1) begin
        rd = data_i;
        got = 1'b1;
      end
      if (ack_out_n_i === 1'b0) chn = 1'b1;
      if (ack_evt_i.valid === 1'b1) ev = ack_evt_i;
    end
    @(posedge mclk_i);
    bus_o <= '{1'b1, 1'b1, 1'b1, ~a, ~wd};
    ack_in_n_o <= 1'b1;
    // The gap lets a chained acknowledge die away before the next strobe.
    repeat (3) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

//--- verification/test_service_request_acknowledge.sv
// Purpose: Self-checking bench of the request and acknowledge block.
// Assumes: Host model owns the bus; bench plays the channel engines.
// Notes:   Identity written to the vector register is 5'h14.
`timescale 1ns/10ps
`default_nettype none
module test_service_request_acknowledge;
  logic                  mclk_i;
  logic                  sys_rst_i;
  srack_pkg::srack_bus_s bus;
  srack_pkg::srack_ack_s ev_w;
  srack_pkg::srack_ack_s ev;
  logic                  ack_in_n, ack_out_n, data_oe, chain_en, got, chn;
  logic [7:0]            data, rd, rxq, txq, mdq;
  logic [2:0]            oe, line_n, other, req_o;
  int                    n_errors, n_compared;

  srack_top DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
    .ack_chain_in_n_i(ack_in_n), .ack_chain_out_n_o(ack_out_n), .data_o(data),
    .data_oe_o(data_oe), .rx_chan_req_i(rxq), .tx_chan_req_i(txq),
    .modem_chan_req_i(mdq), .rx_service_request_n_i(line_n[0]),
    .tx_service_request_n_i(line_n[1]), .modem_service_request_n_i(line_n[2]),
    .rx_service_request_n_o(req_o[0]), .tx_service_request_n_o(req_o[1]),
    .modem_service_request_n_o(req_o[2]), .rx_service_request_n_oe_o(oe[0]),
    .tx_service_request_n_oe_o(oe[1]), .modem_service_request_n_oe_o(oe[2]),
    .ack_evt_o(ev_w), .chain_enable_o(chain_en));

  srack_host_model HOST (.mclk_i(mclk_i), .own_oe_i(oe), .other_req_i(other),
    .data_i(data), .data_oe_i(data_oe), .ack_out_n_i(ack_out_n),
    .ack_evt_i(ev_w), .bus_o(bus), .ack_in_n_o(ack_in_n), .line_n_o(line_n));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    chk8({7'h00, g}, {7'h00, e}, m);
  endtask

  task automatic rd_reg(input logic [6:0] a);
    HOST.cycle(1'b0, 1'b1, 1'b1, a, 8'h00, rd, got, chn, ev);
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    HOST.cycle(1'b0, 1'b1, 1'b0, a, d, rd, got, chn, ev);
  endtask

  task automatic hw_ack();
    HOST.cycle(1'b1, 1'b0, 1'b1, 7'h00, 8'h00, rd, got, chn, ev);
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic t_reset();
    chk1(data_oe, 1'b0, "oe after reset");
    chk1(ack_out_n, 1'b1, "chain out after reset");
    chk1(chain_en, 1'b0, "chain enable after reset");
    chk8({5'h00, oe}, 8'h00, "request oe after reset");
    rd_reg(srack_pkg::ADDR_VECTOR);
    chk8(rd, srack_pkg::VECTOR_RST, "vector reset");
    rd_reg(7'h4f);
    chk8(rd, srack_pkg::READ_UNMAPPED, "unmapped read");
    chk1(got, 1'b1, "unmapped read answered");
  endtask

  task automatic t_sw_ack();
    wr_reg(srack_pkg::ADDR_VECTOR, 8'ha5);
    rd_reg(srack_pkg::ADDR_VECTOR);
    chk8(rd, 8'ha5, "vector readback");
    rxq <= 8'h04;
    other <= 3'b010;
    settle();
    chk8({5'h00, oe}, 8'h01, "rx line pulled");
    chk8({5'h00, req_o}, 8'h00, "open drain level");
    // A single-level host sees the OR of the three active-low lines.
    chk1(|(~line_n), 1'b1, "single interrupt raised");
    rd_reg(srack_pkg::ADDR_STATUS);
    chk8(rd, 8'h19, "status own and shared");
    rd_reg(srack_pkg::ADDR_RX_ACK);
    chk8(rd, 8'ha1, "rx vector");
    chk8({5'h00, ev.kind}, {5'h00, srack_pkg::TYPE_RX}, "rx event kind");
    chk8({5'h00, ev.chan}, 8'h02, "rx event channel");
    rxq <= 8'h00;
    other <= 3'b000;
    settle();
  endtask

  task automatic t_empty();
    rd_reg(srack_pkg::ADDR_TX_ACK);
    chk8(rd, 8'ha0, "empty read zero type");
    chk1(chn, 1'b0, "no chain without enable");
    wr_reg(srack_pkg::ADDR_CTRL, 8'h01);
    chk1(chain_en, 1'b1, "chain enabled");
    rd_reg(srack_pkg::ADDR_MODEM_ACK);
    chk1(chn, 1'b1, "chain out on empty read");
    chk1(got, 1'b0, "no data on chained read");
    wr_reg(srack_pkg::ADDR_CTRL, 8'h00);
  endtask

  task automatic t_hw_ack();
    mdq <= 8'h80;
    settle();
    hw_ack();
    chk8(rd, {5'h14, srack_pkg::TYPE_MODEM}, "hardware vector");
    chk8({5'h00, ev.chan}, 8'h07, "modem event channel");
    chk1(chn, 1'b0, "no pass on hit");
    mdq <= 8'h00;
    settle();
    hw_ack();
    chk1(chn, 1'b1, "passed on when empty");
    chk1(got, 1'b0, "no data when passed");
  endtask

  task automatic t_rr();
    rxq <= 8'h22;
    settle();
    // Receive channel 2 was served last, so the search starts at channel 3.
    rd_reg(srack_pkg::ADDR_RX_ACK);
    chk8({5'h00, ev.chan}, 8'h05, "first pick");
    rd_reg(srack_pkg::ADDR_RX_ACK);
    chk8({5'h00, ev.chan}, 8'h01, "second pick");
    rxq <= 8'h00;
  endtask

  task automatic t_tx();
    txq <= 8'h01;
    settle();
    rd_reg(srack_pkg::ADDR_TX_ACK);
    chk8(rd, 8'ha2, "tx vector");
    chk8({5'h00, ev.kind}, {5'h00, srack_pkg::TYPE_TX}, "tx event kind");
    mdq <= 8'h80;
    settle();
    hw_ack();
    chk8(rd, {5'h14, srack_pkg::TYPE_TX}, "tx served before modem");
    txq <= 8'h00;
    mdq <= 8'h00;
    settle();
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    n_errors = 0;
    n_compared = 0;
    sys_rst_i = 1'b1;
    rxq = 8'h00;
    txq = 8'h00;
    mdq = 8'h00;
    other = 3'b000;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_sw_ack();
    t_empty();
    t_hw_ack();
    t_rr();
    t_tx();
    tally_and_finish();
  end
endmodule
`default_nettype wire
